// File: include/led_sink_params.svh
// timing and layout constants for the led sink error detection block
`ifndef LED_SINK_PARAMS_SVH
`define LED_SINK_PARAMS_SVH
`define CHANNELS          16
`define CLK_PERIOD_NS     100
`define GATE_MIN_NS       120
`define LATCH_ED_MIN_NS   200
`define GATE_MIN_CYC      ((`GATE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LATCH_ED_MIN_CYC  ((`LATCH_ED_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_RESET       16'h0000
`define LATCH_RESET       16'h0000
`endif

// File: include/led_sink_pkg.sv
// types shared by the led sink error detection block
package led_sink_pkg;
	// synchronised serial link levels from the display controller
	typedef struct packed {
		logic link_clk;
		logic serial_in;
		logic latch_strobe_n;
		logic gate_n;
	} link_t;
	// per-channel load sense levels from the analog comparators
	typedef struct packed {
		logic [15:0] open_load;
		logic [15:0] short_load;
	} sense_t;
	typedef enum logic [1:0] {
		LATCH_IDLE,
		LATCH_HIGH,
		LATCH_DONE
	} latch_state_t;
endpackage

// File: logic/pin_sync.sv
// two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// first stage feeds only the second stage
	always_comb
	begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	// registers, reset to zero
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= nxt_meta;
			sync_out <= nxt_sync;
		end
	end
endmodule

// File: logic/led_sink_core.sv
// serial-in parallel-out led sink with on-the-fly open and short detection
// Operation
// - latched 1 turns the channel sink on, latched 0 turns it off
// - open load on a lit channel clears its shift bit from 1 to 0
// - short load on a dark channel sets its shift bit from 0 to 1
// - error status shifts out while new display data shifts in
// - latched 0 channels stay off and get the short check
// - checks change only the shift copy, never latch or sink outputs
// - over-temperature forces all sinks off until the die cools
// - detection runs alongside normal driving, no mode to enter
`timescale 1ns/1ps
`include "led_sink_params.svh"
module led_sink_core (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// serial link pins from the controller
	input  wire logic        link_clk_pin,
	input  wire logic        serial_in_pin,
	input  wire logic        latch_strobe_n,
	input  wire logic        gate_n,
	output logic             serial_out_pin,
	// analog sense and thermal flags (asynchronous levels)
	input  wire logic [15:0] open_load,
	input  wire logic [15:0] short_load,
	input  wire logic        temp_over_hi,
	input  wire logic        temp_under_lo,
	// channel drive
	output logic      [15:0] sink_channel,
	output logic             thermal_off
);
	led_sink_pkg::link_t  link_raw;
	led_sink_pkg::link_t  link_s;
	led_sink_pkg::sense_t sense_s;
	logic [1:0]           temp_s;
	logic [37:0]          sync_bus;

	// every pin level passes two flops before use
	assign link_raw = '{link_clk: link_clk_pin, serial_in: serial_in_pin,
		latch_strobe_n: latch_strobe_n, gate_n: gate_n};

	pin_sync #(
		.WIDTH(38)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({link_raw, open_load, short_load, temp_over_hi, temp_under_lo}),
		.sync_out (sync_bus)
	);

	assign link_s  = sync_bus[37:34];
	assign sense_s = sync_bus[33:2];
	assign temp_s  = sync_bus[1:0];

	// edge history of synchronised link levels, then shift, latch, drive, timer and state registers
	logic        link_clk_d_ff;
	logic        strobe_d_ff;
	logic [15:0] shift_ff;
	logic [15:0] latch_ff;
	logic        sout_ff;
	logic [15:0] sink_ff;
	logic        hot_ff;
	logic [3:0]  gate_cnt_ff;
	logic [3:0]  strobe_cnt_ff;
	logic        open_ok_ff;
	led_sink_pkg::latch_state_t state_ff;

	logic        nxt_link_clk_d;
	logic        nxt_strobe_d;
	logic [15:0] nxt_shift;
	logic [15:0] nxt_latch;
	logic        nxt_sout;
	logic [15:0] nxt_sink;
	logic        nxt_hot;
	logic [3:0]  nxt_gate_cnt;
	logic [3:0]  nxt_strobe_cnt;
	logic        nxt_open_ok;
	led_sink_pkg::latch_state_t nxt_state;

	logic clk_rise;
	logic strobe_rise;
	logic strobe_fall;

	// saturating counter step, used by both pulse width timers
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction

	assign clk_rise    = link_s.link_clk & ~link_clk_d_ff;
	assign strobe_rise = link_s.latch_strobe_n & ~strobe_d_ff;
	assign strobe_fall = ~link_s.latch_strobe_n & strobe_d_ff;

	// next-state logic for shift, latch, detection and drive
	always_comb
	begin
		nxt_link_clk_d = link_s.link_clk;
		nxt_strobe_d   = link_s.latch_strobe_n;
		nxt_shift      = shift_ff;
		nxt_latch      = latch_ff;
		nxt_state      = state_ff;
		nxt_open_ok    = open_ok_ff;
		// gate width timer: open check is trusted only past the minimum low time
		nxt_gate_cnt   = link_s.gate_n ? 4'h0 : sat_inc(gate_cnt_ff);
		if (gate_cnt_ff >= 4'(`GATE_MIN_CYC))
			nxt_open_ok = 1'b1;
		if (link_s.gate_n)
			nxt_open_ok = 1'b0;
		nxt_strobe_cnt = link_s.latch_strobe_n ? sat_inc(strobe_cnt_ff) : 4'h0;
		// shift on each link clock rise; the last stage feeds the cascade
		if (clk_rise)
			nxt_shift = {shift_ff[14:0], link_s.serial_in};
		unique case (state_ff)
			led_sink_pkg::LATCH_IDLE:
			begin
				if (strobe_rise)
				begin
					nxt_latch = shift_ff;
					nxt_state = led_sink_pkg::LATCH_HIGH;
				end
			end
			led_sink_pkg::LATCH_HIGH:
			begin
				// latch is transparent while the strobe stays high, until status is captured
				if (!strobe_fall)
					nxt_latch = shift_ff;
				// status is captured once the strobe has been high the minimum time, or at an earlier strobe fall, no mode needed
				if (strobe_fall || strobe_cnt_ff >= 4'(`LATCH_ED_MIN_CYC))
				begin
					nxt_state = led_sink_pkg::LATCH_DONE;
					for (int i = 0; i < `CHANNELS; i++)
					begin
						if (nxt_latch[i] && open_ok_ff && sense_s.open_load[i])
							nxt_shift[i] = 1'b0;
						else if (!nxt_latch[i] && sense_s.short_load[i])
							nxt_shift[i] = 1'b1;
					end
				end
			end
			led_sink_pkg::LATCH_DONE:
			begin
				if (!link_s.latch_strobe_n)
					nxt_state = led_sink_pkg::LATCH_IDLE;
			end
		endcase
		// thermal hysteresis: trip high, release only once cooled
		nxt_hot = hot_ff;
		if (temp_s[1])
			nxt_hot = 1'b1;
		else if (temp_s[0])
			nxt_hot = 1'b0;
		// drive comes only from the latch, never from the status copy
		nxt_sink = (link_s.gate_n || hot_ff) ? 16'h0000 : latch_ff;
		nxt_sout = nxt_shift[15];
	end

	// registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			link_clk_d_ff <= 1'b0;
			strobe_d_ff   <= 1'b0;
			shift_ff      <= `SHIFT_RESET;
			latch_ff      <= `LATCH_RESET;
			sout_ff       <= 1'b0;
			sink_ff       <= 16'h0000;
			hot_ff        <= 1'b0;
			gate_cnt_ff   <= 4'h0;
			strobe_cnt_ff <= 4'h0;
			open_ok_ff    <= 1'b0;
			state_ff      <= led_sink_pkg::LATCH_IDLE;
		end
		else
		begin
			link_clk_d_ff <= nxt_link_clk_d;
			strobe_d_ff   <= nxt_strobe_d;
			shift_ff      <= nxt_shift;
			latch_ff      <= nxt_latch;
			sout_ff       <= nxt_sout;
			sink_ff       <= nxt_sink;
			hot_ff        <= nxt_hot;
			gate_cnt_ff   <= nxt_gate_cnt;
			strobe_cnt_ff <= nxt_strobe_cnt;
			open_ok_ff    <= nxt_open_ok;
			state_ff      <= nxt_state;
		end
	end

	assign serial_out_pin = sout_ff;
	assign sink_channel   = sink_ff;
	assign thermal_off    = hot_ff;
endmodule

// File: tb/led_sink_core_assertions.sv
// port checks for the led sink core
`timescale 1ns/1ps
module led_sink_core_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// link pins
	input wire logic        link_clk_pin,
	input wire logic        latch_strobe_n,
	input wire logic        gate_n,
	input wire logic        serial_out_pin,
	// thermal and drive
	input wire logic        temp_over_hi,
	input wire logic        temp_under_lo,
	input wire logic [15:0] sink_channel,
	input wire logic        thermal_off
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// quiet display: latched, gated on, cool
	sequence s_quiet;
		(!latch_strobe_n && !gate_n && !thermal_off)[*8];
	endsequence
	property p_steady;
		s_quiet |=> $stable(sink_channel);
	endproperty
	a_steady: assert property (p_steady) else $error("sinks moved while idle");
	property p_gate;
		gate_n[*6] |-> sink_channel == 16'h0000;
	endproperty
	a_gate: assert property (p_gate) else $error("sinks on while gated off");
	property p_hot;
		temp_over_hi[*4] |-> thermal_off;
	endproperty
	a_hot: assert property (p_hot) else $error("no thermal shutdown");
	property p_hot_off;
		thermal_off[*2] |-> sink_channel == 16'h0000;
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("sinks on while hot");
	property p_cool;
		(temp_under_lo && !temp_over_hi)[*5] |-> !thermal_off;
	endproperty
	a_cool: assert property (p_cool) else $error("no recovery when cool");
	// leaving shutdown needs the cool flag a few cycles earlier
	property p_hyst;
		!$past(rst) && $fell(thermal_off) |-> $past(temp_under_lo, 2) || $past(temp_under_lo, 3);
	endproperty
	a_hyst: assert property (p_hyst) else $error("shutdown left early");
	property p_sout;
		!$past(rst) && $changed(serial_out_pin) |-> $past(link_clk_pin, 2)
			|| $past(link_clk_pin, 4) || $past(latch_strobe_n, 4) || $past(latch_strobe_n, 6);
	endproperty
	a_sout: assert property (p_sout) else $error("serial out moved unprompted");
	// the default disable would mute this check, since its trigger is reset itself
	property p_rst;
		disable iff (1'b0)
		rst |=> sink_channel == 16'h0000 && !serial_out_pin && !thermal_off;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind led_sink_core led_sink_core_assertions chk (.clk, .rst, .link_clk_pin, .latch_strobe_n,
	.gate_n, .serial_out_pin, .temp_over_hi, .temp_under_lo, .sink_channel, .thermal_off);

// File: tb/display_ctrl_model.sv
// display controller model driving the serial link
`timescale 1ns/1ps
module display_ctrl_model (
	// clock
	input wire logic clk,
	// link pins
	output logic     link_clk_pin,
	output logic     serial_in_pin,
	output logic     latch_strobe_n,
	output logic     gate_n,
	input wire logic serial_out_pin
);
	// link idles low, gate idles off like its pull-up
	initial
	begin
		link_clk_pin = 1'b0;
		serial_in_pin = 1'b0;
		latch_strobe_n = 1'b0;
		gate_n = 1'b1;
	end
	// gate is held for whole frames, far longer than the check minimum
	task automatic gate(input logic v);
		gate_n <= v;
	endtask
	// msb first; status is read before each rising edge
	task automatic send(input logic [15:0] d, output logic [15:0] q);
		for (int i = 15; i >= 0; i--)
		begin
			serial_in_pin <= d[i];
			repeat (4) @(posedge clk);
			q[i] = serial_out_pin;
			link_clk_pin <= 1'b1;
			repeat (4) @(posedge clk);
			link_clk_pin <= 1'b0;
		end
		serial_in_pin <= ~serial_in_pin; // released line must not look held
	endtask
	// 300 ns pulse lets the outputs settle before status capture
	task automatic strobe();
		latch_strobe_n <= 1'b1;
		repeat (3) @(posedge clk);
		latch_strobe_n <= 1'b0;
	endtask
endmodule

// File: tb/led_sink_core_tb.sv
// self-checking bench for the led sink core
`timescale 1ns/1ps
module led_sink_core_tb;
	typedef struct packed {
		logic [15:0] d;
		logic [15:0] op;
		logic [15:0] sh;
		logic [15:0] st;
	} row_t;
	logic        clk;
	logic        rst;
	logic        link_clk_pin;
	logic        serial_in_pin;
	logic        latch_strobe_n;
	logic        gate_n;
	logic        serial_out_pin;
	logic [15:0] open_load;
	logic [15:0] short_load;
	logic        temp_over_hi;
	logic        temp_under_lo;
	logic [15:0] sink_channel;
	logic        thermal_off;
	logic [15:0] rd;
	int          fail_count;
	int          num_checks;
	// display word, open flags, short flags, status read back
	row_t rows [4] = '{'{16'hA5C3, 16'h0000, 16'h0000, 16'hA5C3},
		'{16'hFFFF, 16'h0101, 16'h0000, 16'hFEFE},
		'{16'h0000, 16'h0000, 16'h8001, 16'h8001},
		'{16'h1234, 16'hFFFF, 16'hFFFF, 16'hEDCB}};
	led_sink_core dut (.clk, .rst, .link_clk_pin, .serial_in_pin, .latch_strobe_n, .gate_n,
		.serial_out_pin, .open_load, .short_load, .temp_over_hi, .temp_under_lo,
		.sink_channel, .thermal_off);
	display_ctrl_model ctl (.clk, .link_clk_pin, .serial_in_pin, .latch_strobe_n, .gate_n,
		.serial_out_pin);
	always #50 clk = ~clk;
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// about 100 us of traffic expected
	initial
	begin
		#300000;
		fail_count++;
		results();
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		open_load = 16'h0000;
		short_load = 16'h0000;
		temp_over_hi = 1'b0;
		temp_under_lo = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset sinks", 16'h0000, sink_channel);
		ctl.gate(1'b0);
		foreach (rows[i])
		begin
			open_load <= rows[i].op;
			short_load <= rows[i].sh;
			ctl.send(rows[i].d, rd);
			if (i > 0) check("status", rows[i-1].st, rd);
			ctl.strobe();
			repeat (10) @(posedge clk);
			check("sinks", rows[i].d, sink_channel);
		end
		ctl.send(16'h0000, rd);
		check("last status", rows[3].st, rd);
		ctl.gate(1'b1);
		repeat (8) @(posedge clk);
		check("gated sinks", 16'h0000, sink_channel);
		ctl.gate(1'b0);
		repeat (8) @(posedge clk);
		check("unlatched shift", rows[3].d, sink_channel);
		temp_over_hi <= 1'b1;
		repeat (6) @(posedge clk);
		check("hot sinks", 16'h0000, sink_channel);
		temp_over_hi <= 1'b0;
		repeat (6) @(posedge clk);
		check("hysteresis", 16'h0001, 16'(thermal_off));
		temp_under_lo <= 1'b1;
		repeat (8) @(posedge clk);
		check("cooled sinks", rows[3].d, sink_channel);
		// gate held off across the strobe: open loads must go unreported
		ctl.gate(1'b1);
		open_load <= 16'hFFFF;
		short_load <= 16'h0000;
		ctl.send(16'h00FF, rd);
		check("idle status", 16'h0000, rd);
		ctl.strobe();
		repeat (10) @(posedge clk);
		check("gated latch", 16'h0000, sink_channel);
		ctl.send(16'h0000, rd);
		check("gated status", 16'h00FF, rd);
		ctl.gate(1'b0);
		repeat (8) @(posedge clk);
		check("reopened sinks", 16'h00FF, sink_channel);
		results();
	end
endmodule
